// ---- rtl/legacy_reg_access.v ----
// What this block does
// - Index byte selects, data byte accesses register
// - One shared legacy I/O base for both
// - Index 00-3F socket A, 40-7F socket B
// - Memory alias at 800h in config-10h window
// - Each function has own memory base
// - Alias spans offsets 800h through 844h
// - Socket registers at offset 0h, same window
// - Two I/O windows per socket
// - I/O window bounds at byte granularity
// - Five memory windows per socket
// - Memory windows use 4K granularity
// - Context bits survive bus reset only with pme_enable set, global clears
// - D3hot to D0 resets all other registers
//
// Holds both sockets' legacy register sets, indexed I/O and memory alias
// access, and the I/O and memory window translators.
// Assumes a host bridge that presents one decoded access per mclk pulse.
`timescale 1ns/1ps
`include "legacy_access_consts.vh"

module legacy_reg_access #(
    parameter CONTEXT_MASK = 64'h0000_0000_0000_0034
) (
    // Clock and resets
    input  wire        mclk,
    input  wire        rst,
    input  wire        pci_bus_reset_n,
    input  wire        d3hot_to_d0,
    input  wire        pme_enable,
    // Base addresses from configuration space
    input  wire [15:0] legacy_io_base,
    input  wire [19:0] mem_base_fn0,
    input  wire [19:0] mem_base_fn1,
    // Host access
    input  wire        acc_valid,
    input  wire        acc_is_io,
    input  wire        acc_write,
    input  wire [31:0] acc_addr,
    input  wire [7:0]  acc_wdata,
    // Access answer
    output reg         acc_hit,
    output reg  [7:0]  acc_rdata,
    output reg         sock_reg_hit,
    output reg  [10:0] sock_reg_ofs,
    output reg         sock_reg_fn,
    // Window translation for the host address
    input  wire        xlat_sock,
    input  wire [15:0] xlat_io_addr,
    input  wire [23:0] xlat_mem_addr,
    output reg         io_win_hit,
    output reg  [15:0] io_card_addr,
    output reg         mem_win_hit,
    output reg  [25:0] mem_card_addr
);

    // ------------------------------------------------------------------
    // Pin synchroniser for the bus reset
    // ------------------------------------------------------------------
    reg        pci_bus_reset_n_meta;
    reg        pci_bus_reset_n_sync;

    always @(posedge mclk)
    begin
        if (rst)
        begin
            pci_bus_reset_n_meta <= 1'b0;
            pci_bus_reset_n_sync <= 1'b0;
        end
        else
        begin
            pci_bus_reset_n_meta <= ~pci_bus_reset_n;
            pci_bus_reset_n_sync <= pci_bus_reset_n_meta;
        end
    end

    // ------------------------------------------------------------------
    // Register storage and index
    // ------------------------------------------------------------------
    reg [7:0] regs [0:127];
    reg [7:0] index;
    integer   i;

    function [6:0] io_win_reg;
        input       sock;
        input [0:0] win;
        input [1:0] byte_sel;
        begin
            io_win_reg = {sock, `REG_IO0_BASE + {3'h0, win, 2'h0}
                          + {4'h0, byte_sel}};
        end
    endfunction

    function [6:0] mem_win_reg;
        input       sock;
        input [2:0] win;
        input [2:0] byte_sel;
        begin
            mem_win_reg = {sock, `REG_MEM0_BASE + {win, 3'h0}
                           + {3'h0, byte_sel}};
        end
    endfunction

    function [6:0] io_ofs_reg;
        input       sock;
        input [0:0] win;
        input [0:0] byte_sel;
        begin
            io_ofs_reg = {sock, `REG_IO0_OFS_BASE + {4'h0, win, byte_sel}};
        end
    endfunction

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire        io_index_hit = acc_valid && acc_is_io
                && (acc_addr[15:0] == legacy_io_base)
                && (acc_addr[0] == `IO_INDEX_OFS);
    wire        io_data_hit  = acc_valid && acc_is_io
                && (acc_addr[15:0] == legacy_io_base + 16'h0001)
                && !index[7];
    wire        mem_fn0 = acc_valid && !acc_is_io
                && (acc_addr[31:12] == mem_base_fn0);
    wire        mem_fn1 = acc_valid && !acc_is_io
                && (acc_addr[31:12] == mem_base_fn1);
    wire [11:0] win_ofs = acc_addr[11:0];
    wire        alias_hit = (mem_fn0 || mem_fn1)
                && (win_ofs >= `ALIAS_BASE)
                && (win_ofs <= `ALIAS_LAST);
    wire        alias_reg = alias_hit
                && (win_ofs[6:0] <= {1'b0, `INDEX_MASK});
    wire        sock_hit = (mem_fn0 || mem_fn1)
                && (win_ofs <= `SOCKET_REGS_LAST);
    // Alias picks the function's socket; low bits match the index
    wire [6:0]  alias_sel = {mem_fn1, win_ofs[5:0]};
    wire [6:0]  sel = io_data_hit ? index[6:0] : alias_sel;
    wire        reg_hit = io_data_hit || alias_reg;

    // ------------------------------------------------------------------
    // Register write and resets
    // ------------------------------------------------------------------
    wire       soft_reset = pci_bus_reset_n_sync || d3hot_to_d0;

    always @(posedge mclk)
    begin
        if (rst)
        begin
            index <= `REG_RESET_VALUE;
            for (i = 0; i < 128; i = i + 1)
                regs[i] <= `REG_RESET_VALUE;
        end
        else
        begin
            if (soft_reset)
            begin
                index <= `REG_RESET_VALUE;
                for (i = 0; i < 128; i = i + 1)
                    if (!(CONTEXT_MASK[i % 64] && pme_enable))
                        regs[i] <= `REG_RESET_VALUE;
            end
            else if (acc_write && io_index_hit)
                index <= acc_wdata;
            else if (acc_write && reg_hit)
                regs[sel] <= acc_wdata;
        end
    end

    // ------------------------------------------------------------------
    // Access answer
    // ------------------------------------------------------------------
    always @(posedge mclk)
    begin
        if (rst)
        begin
            acc_hit      <= 1'b0;
            acc_rdata    <= 8'h00;
            sock_reg_hit <= 1'b0;
            sock_reg_ofs <= 11'h000;
            sock_reg_fn  <= 1'b0;
        end
        else
        begin
            acc_hit      <= io_index_hit || reg_hit || alias_hit || sock_hit;
            acc_rdata    <= io_index_hit ? index
                            : (reg_hit ? regs[sel] : 8'h00);
            sock_reg_hit <= sock_hit;
            sock_reg_ofs <= win_ofs[10:0];
            sock_reg_fn  <= mem_fn1;
        end
    end

    // ------------------------------------------------------------------
    // Window translators
    // ------------------------------------------------------------------
    wire [1:0]  io_hit;
    wire [31:0] io_card;
    wire [4:0]  mem_hit;
    wire [59:0] mem_card;

    genvar w;
    generate
        for (w = 0; w < `IO_WIN_COUNT; w = w + 1)
        begin : g_io
            wire [31:0] wn = w;
            // Byte grain: full 16-bit bounds
            window_match #(.AW(16)) u_io (
                .enable     (regs[{xlat_sock, `REG_WIN_ENABLE}][6 + w]),
                .start_addr ({regs[io_win_reg(xlat_sock, wn[0:0], 2'd1)],
                              regs[io_win_reg(xlat_sock, wn[0:0], 2'd0)]}),
                .end_addr   ({regs[io_win_reg(xlat_sock, wn[0:0], 2'd3)],
                              regs[io_win_reg(xlat_sock, wn[0:0], 2'd2)]}),
                .offset     ({regs[io_ofs_reg(xlat_sock, wn[0:0], 1'b1)],
                              regs[io_ofs_reg(xlat_sock, wn[0:0], 1'b0)]}),
                .host_addr  (xlat_io_addr),
                .hit        (io_hit[w]),
                .card_addr  (io_card[16*w +: 16])
            );
        end
        for (w = 0; w < `MEM_WIN_COUNT; w = w + 1)
        begin : g_mem
            wire [31:0] wn = w;
            // 4K grain: compare and add on address bits 23:12
            window_match #(.AW(12)) u_mem (
                .enable     (regs[{xlat_sock, `REG_WIN_ENABLE}][w]),
                .start_addr ({regs[mem_win_reg(xlat_sock, wn[2:0], 3'd1)][3:0],
                              regs[mem_win_reg(xlat_sock, wn[2:0], 3'd0)]}),
                .end_addr   ({regs[mem_win_reg(xlat_sock, wn[2:0], 3'd3)][3:0],
                              regs[mem_win_reg(xlat_sock, wn[2:0], 3'd2)]}),
                .offset     ({regs[mem_win_reg(xlat_sock, wn[2:0], 3'd5)][3:0],
                              regs[mem_win_reg(xlat_sock, wn[2:0], 3'd4)]}),
                .host_addr  (xlat_mem_addr[23:12]),
                .hit        (mem_hit[w]),
                .card_addr  (mem_card[12*w +: 12])
            );
        end
    endgenerate

    reg        next_mem_hit;
    reg [11:0] next_mem_page;
    integer    k;

    // Lowest-numbered hitting window wins on overlap
    always @*
    begin
        next_mem_hit  = 1'b0;
        next_mem_page = 12'h000;
        for (k = `MEM_WIN_COUNT - 1; k >= 0; k = k - 1)
            if (mem_hit[k])
            begin
                next_mem_hit  = 1'b1;
                next_mem_page = mem_card[12*k +: 12];
            end
    end

    always @(posedge mclk)
    begin
        if (rst)
        begin
            io_win_hit    <= 1'b0;
            io_card_addr  <= 16'h0000;
            mem_win_hit   <= 1'b0;
            mem_card_addr <= 26'h0000000;
        end
        else
        begin
            io_win_hit    <= |io_hit;
            io_card_addr  <= io_hit[0] ? io_card[15:0] : io_card[31:16];
            mem_win_hit   <= next_mem_hit;
            mem_card_addr <= {2'b00, next_mem_page,
                              xlat_mem_addr[`MEM_GRAIN_BITS-1:0]};
        end
    end

endmodule // legacy_reg_access

// ---- rtl/legacy_access_consts.vh ----
// Offsets, field positions and reset values of the legacy register set.
// Assumes inclusion by the legacy access modules only.
`ifndef LEGACY_ACCESS_CONSTS_VH
`define LEGACY_ACCESS_CONSTS_VH

// ----------------------------------------------------------------------
// Host address decode
// ----------------------------------------------------------------------
`define IO_INDEX_OFS      1'b0
`define IO_DATA_OFS       1'b1
`define ALIAS_BASE        12'h800
`define ALIAS_LAST        12'h844
`define SOCKET_REGS_LAST  12'h7ff
`define SOCKET_B_BIT      6
`define INDEX_MASK        7'h3f

// ----------------------------------------------------------------------
// Window and control register offsets inside one socket's set
// ----------------------------------------------------------------------
`define REG_WIN_ENABLE    6'h06
`define REG_IO_CTRL       6'h07
`define REG_IO0_BASE      6'h08
`define REG_IO_STRIDE     6'h04
`define REG_MEM0_BASE     6'h10
`define REG_MEM_STRIDE    6'h08
`define REG_IO0_OFS_BASE  6'h36
`define REG_INT_GEN_CTRL  6'h03
`define REG_CSC_INT_CFG   6'h05
`define REG_POWER_CTRL    6'h02
`define REG_CSC           6'h04

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define REG_RESET_VALUE   8'h00
`define IO_WIN_COUNT      2
`define MEM_WIN_COUNT     5
`define MEM_GRAIN_BITS    12

`endif

// ---- rtl/window_match.v ----
// One host-to-card address window: hit test and offset translation.
// Assumes start, end and offset already aligned to the window grain.
`timescale 1ns/1ps

module window_match #(
    parameter AW = 16
) (
    // Window setup
    input  wire          enable,
    input  wire [AW-1:0] start_addr,
    input  wire [AW-1:0] end_addr,
    input  wire [AW-1:0] offset,
    // Host address
    input  wire [AW-1:0] host_addr,
    // Result
    output wire          hit,
    output wire [AW-1:0] card_addr
);

    // Inclusive bounds, offset added modulo the window width
    assign hit       = enable && (host_addr >= start_addr)
                       && (host_addr <= end_addr);
    assign card_addr = host_addr + offset;

endmodule // window_match

// ---- bench/host_model.sv ----
// Host bridge stand-in issuing one I/O or memory cycle at a time.
// Assumes the block answers on the edge that takes the access.
`timescale 1ns/1ps

module host_model (
    // Clock
    input  wire        mclk,
    // Host access
    output logic       acc_valid,
    output logic       acc_is_io,
    output logic       acc_write,
    output logic [31:0] acc_addr,
    output logic [7:0] acc_wdata,
    // Answer
    input  wire  [7:0] acc_rdata
);
    initial
    begin
        acc_valid = 1'b0;
        acc_is_io = 1'b0;
        acc_write = 1'b0;
        acc_addr  = 32'h0;
        acc_wdata = 8'h0;
    end

    // Idle bus shows inverted address and data, never their last values
    task access(input logic io, wr, input logic [31:0] a,
                input logic [7:0] d, output logic [7:0] q);
    begin
        @(negedge mclk);
        acc_valid = 1'b1;
        acc_is_io = io;
        acc_write = wr;
        acc_addr  = a;
        acc_wdata = d;
        @(negedge mclk);
        q         = acc_rdata;
        acc_valid = 1'b0;
        acc_addr  = ~a;
        acc_wdata = ~d;
    end
    endtask
endmodule // host_model

// ---- bench/legacy_reg_access_asserts.sv ----
// Port-level checks of the legacy register access block.
// Assumes one clock and the synchronous reset rst.
`timescale 1ns/1ps

module legacy_reg_access_asserts (
    // Clock and reset
    input wire        mclk,
    input wire        rst,
    // Host access and bases
    input wire        acc_valid,
    input wire        acc_is_io,
    input wire        acc_write,
    input wire [31:0] acc_addr,
    input wire [7:0]  acc_wdata,
    input wire [15:0] legacy_io_base,
    input wire [19:0] mem_base_fn0,
    input wire [19:0] mem_base_fn1,
    // Answers
    input wire        acc_hit,
    input wire        sock_reg_hit,
    input wire [10:0] sock_reg_ofs,
    input wire        sock_reg_fn,
    input wire [23:0] xlat_mem_addr,
    input wire        io_win_hit,
    input wire        mem_win_hit,
    input wire [25:0] mem_card_addr
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    wire mv = acc_valid && !acc_is_io;
    wire m0 = mv && acc_addr[31:12] == mem_base_fn0;
    wire m1 = mv && acc_addr[31:12] == mem_base_fn1 && !m0;
    wire lo = acc_addr[11:0] <= 12'h7ff;
    // Last index written has bit 7 set: data port is refused then
    reg  idx_hi;
    wire ix_wr = acc_valid && acc_is_io && acc_write && !acc_addr[0]
        && acc_addr[15:0] == legacy_io_base;
    always @(posedge mclk)
    begin
        if (rst)
            idx_hi <= 1'b0;
        else if (ix_wr)
            idx_hi <= acc_wdata[7];
    end
    wire io = acc_valid && acc_is_io && acc_addr[31:16] == 16'h0 &&
        ((acc_addr[15:0] == legacy_io_base && !acc_addr[0]) ||
         (acc_addr[15:0] == legacy_io_base + 16'h1 && !idx_hi));

    sock_reg_fn0_a: assert property (m0 && lo |=> sock_reg_hit
        && !sock_reg_fn && sock_reg_ofs == $past(acc_addr[10:0]))
        else $error("socket register decode wrong for function 0");
    sock_reg_fn1_a: assert property (m1 && lo |=> sock_reg_hit
        && sock_reg_fn) else $error("function 1 window not decoded");
    alias_hit_a: assert property ((m0 || m1) && !lo &&
        acc_addr[11:0] <= 12'h844 |=> acc_hit && !sock_reg_hit)
        else $error("alias access missed");
    alias_end_a: assert property (mv && acc_addr[11:0] > 12'h844
        |=> !acc_hit) else $error("hit beyond alias end");
    io_pair_a: assert property (io |=> acc_hit)
        else $error("index or data port missed");
    idle_miss_a: assert property (!acc_valid |=> !acc_hit)
        else $error("hit without access");
    mem_grain_a: assert property (mem_win_hit |->
        mem_card_addr[11:0] == $past(xlat_mem_addr[11:0]))
        else $error("memory window moved low address bits");
    rst_clear_a: assert property (disable iff (1'b0) rst |=>
        !acc_hit && !io_win_hit && !mem_win_hit)
        else $error("outputs not cleared by reset");
endmodule // legacy_reg_access_asserts

bind legacy_reg_access legacy_reg_access_asserts u_chk (
    .mclk(mclk), .rst(rst), .acc_valid(acc_valid), .acc_is_io(acc_is_io),
    .acc_write(acc_write), .acc_wdata(acc_wdata),
    .acc_addr(acc_addr), .legacy_io_base(legacy_io_base),
    .mem_base_fn0(mem_base_fn0), .mem_base_fn1(mem_base_fn1),
    .acc_hit(acc_hit), .sock_reg_hit(sock_reg_hit),
    .sock_reg_ofs(sock_reg_ofs), .sock_reg_fn(sock_reg_fn),
    .xlat_mem_addr(xlat_mem_addr), .io_win_hit(io_win_hit),
    .mem_win_hit(mem_win_hit), .mem_card_addr(mem_card_addr));

// ---- bench/tb.sv ----
// Self-checking bench: indexed and aliased access, windows, resets.
// Assumes host_model drives the access port and the bound checker.
`timescale 1ns/1ps

module tb;
    // Clock, resets, configuration and translation requests
    logic        mclk, rst, bus_rst_n, d3hot, pme, xsock;
    logic [15:0] io_base, xio;
    logic [19:0] mb0, mb1;
    logic [23:0] xmem;
    logic [7:0]  q;
    // Host side and answers
    wire         acc_valid, acc_is_io, acc_write, acc_hit;
    wire  [31:0] acc_addr;
    wire  [7:0]  acc_wdata, acc_rdata;
    wire         sock_reg_hit, sock_reg_fn, io_win_hit, mem_win_hit;
    wire  [10:0] sock_reg_ofs;
    wire  [15:0] io_card_addr;
    wire  [25:0] mem_card_addr;
    int          n_mismatch = 0;
    int          cmp_count = 0;

    legacy_reg_access u_dut (.mclk(mclk), .rst(rst),
        .pci_bus_reset_n(bus_rst_n), .d3hot_to_d0(d3hot), .pme_enable(pme),
        .legacy_io_base(io_base), .mem_base_fn0(mb0), .mem_base_fn1(mb1),
        .acc_valid(acc_valid), .acc_is_io(acc_is_io),
        .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .acc_hit(acc_hit), .acc_rdata(acc_rdata),
        .sock_reg_hit(sock_reg_hit), .sock_reg_ofs(sock_reg_ofs),
        .sock_reg_fn(sock_reg_fn), .xlat_sock(xsock), .xlat_io_addr(xio),
        .xlat_mem_addr(xmem), .io_win_hit(io_win_hit),
        .io_card_addr(io_card_addr), .mem_win_hit(mem_win_hit),
        .mem_card_addr(mem_card_addr));
    host_model u_host (.mclk(mclk), .acc_valid(acc_valid),
        .acc_is_io(acc_is_io), .acc_write(acc_write), .acc_addr(acc_addr),
        .acc_wdata(acc_wdata), .acc_rdata(acc_rdata));

    task check(input string nm, input logic [25:0] got, exp);
    begin
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    end
    endtask
    task io_rw(input logic wr, input logic [7:0] idx, d);
    begin
        u_host.access(1'b1, 1'b1, {16'h0, io_base}, idx, q);
        u_host.access(1'b1, wr, {16'h0, io_base + 16'h1}, d, q);
    end
    endtask
    task rd(input string nm, input logic [7:0] idx, exp);
    begin
        io_rw(1'b0, idx, 8'h00);
        check(nm, {18'h0, q}, {18'h0, exp});
    end
    endtask
    // Low byte then high byte of a window bound
    task wr2(input logic [7:0] idx, input logic [15:0] v);
    begin
        io_rw(1'b1, idx, v[7:0]);
        io_rw(1'b1, idx + 8'h1, v[15:8]);
    end
    endtask
    task mem(input logic fn, wr, input logic [11:0] ofs, input logic [7:0] d);
    begin
        u_host.access(1'b0, wr, {fn ? mb1 : mb0, ofs}, d, q);
    end
    endtask
    task xl(input logic s, input logic [15:0] i, input logic [23:0] m);
    begin
        @(negedge mclk);
        xsock = s;
        xio   = i;
        xmem  = m;
        @(negedge mclk);
    end
    endtask

    task t_index;
    begin
        io_rw(1'b1, 8'h10, 8'ha5);
        io_rw(1'b1, 8'h50, 8'h3c);
        io_rw(1'b1, 8'h80, 8'hff);
        rd("idx_bit7_drop", 8'h00, 8'h00);
        rd("sock_a_reg", 8'h10, 8'ha5);
        rd("sock_b_reg", 8'h50, 8'h3c);
    end
    endtask
    task t_alias;
    begin
        mem(1'b0, 1'b0, 12'h810, 8'h00);
        check("alias_fn0", {18'h0, q}, 26'ha5);
        mem(1'b1, 1'b0, 12'h810, 8'h00);
        check("alias_fn1", {18'h0, q}, 26'h3c);
        mem(1'b1, 1'b1, 12'h811, 8'h77);
        rd("alias_write", 8'h51, 8'h77);
        mem(1'b0, 1'b1, 12'h803, 8'h21);
        mem(1'b0, 1'b1, 12'h805, 8'h12);
        rd("int_route", 8'h03, 8'h21);
        rd("int_signal", 8'h05, 8'h12);
        mem(1'b0, 1'b0, 12'h004, 8'h00);
        mem(1'b1, 1'b0, 12'h008, 8'h00);
        mem(1'b0, 1'b0, 12'h900, 8'h00);
    end
    endtask
    task t_iowin;
    begin
        wr2(8'h08, 16'h1234);
        wr2(8'h0a, 16'h1236);
        wr2(8'h36, 16'h0100);
        io_rw(1'b1, 8'h06, 8'h40);
        xl(1'b0, 16'h1236, 24'h0);
        check("io_hit_end", {io_win_hit, io_card_addr}, 17'h11336);
        xl(1'b0, 16'h1237, 24'h0);
        check("io_miss_past", {25'h0, io_win_hit}, 26'h0);
        xl(1'b0, 16'h1233, 24'h0);
        check("io_miss_below", {25'h0, io_win_hit}, 26'h0);
    end
    endtask
    task t_memwin;
    begin
        wr2(8'h70, 16'h000a);
        wr2(8'h72, 16'h000b);
        wr2(8'h74, 16'h0005);
        io_rw(1'b1, 8'h46, 8'h10);
        xl(1'b1, 16'h0, 24'h00bfff);
        check("mem_hit", {25'h0, mem_win_hit}, 26'h1);
        check("mem_card", mem_card_addr, 26'h010fff);
        xl(1'b1, 16'h0, 24'h00c000);
        check("mem_miss", {25'h0, mem_win_hit}, 26'h0);
    end
    endtask
    // Bus reset pin low for four cycles, then sync latency allowed
    task bus_reset;
    begin
        @(negedge mclk) bus_rst_n = 1'b0;
        repeat (4) @(negedge mclk);
        bus_rst_n = 1'b1;
        repeat (4) @(negedge mclk);
    end
    endtask
    task t_resets;
    begin
        io_rw(1'b1, 8'h02, 8'h5a);
        bus_reset;
        rd("ctx_kept", 8'h02, 8'h5a);
        rd("plain_cleared", 8'h10, 8'h00);
        io_rw(1'b1, 8'h10, 8'h11);
        @(negedge mclk) d3hot = 1'b1;
        @(negedge mclk) d3hot = 1'b0;
        rd("d3_cleared", 8'h10, 8'h00);
        @(negedge mclk) rst = 1'b1;
        repeat (4) @(negedge mclk);
        rst = 1'b0;
        rd("global_clear", 8'h02, 8'h00);
        pme = 1'b0;
        io_rw(1'b1, 8'h02, 8'h5a);
        bus_reset;
        rd("ctx_no_pme", 8'h02, 8'h00);
    end
    endtask

    task tally_and_finish;
    begin
        if (n_mismatch == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial
    begin
        #200000;
        n_mismatch++;
        tally_and_finish;
    end
    initial
    begin
        {rst, bus_rst_n, pme, d3hot, xsock} = 5'h1c;
        {io_base, xio, xmem} = {16'h03e0, 16'h0, 24'h0};
        {mb0, mb1} = {20'hc0000, 20'hc0001};
        repeat (4) @(negedge mclk);
        rst = 1'b0;
        t_index;
        t_alias;
        t_iowin;
        t_memwin;
        t_resets;
        tally_and_finish;
    end
endmodule // tb
